// >>> verilog/id_readout_defines.svh
/*
 * Constants shared by both ends of the identification readout link:
 * command codes, checksum parameters, response layout, scale factors, timing.
 * Assumes a 250 MHz system clock on both ends.
 */
`ifndef ID_READOUT_DEFINES_SVH
`define ID_READOUT_DEFINES_SVH

`define CMD_ID_FIRST   16'h367C
`define CMD_ID_SECOND  16'hE102
`define CRC_POLY       8'h31
`define CRC_INIT       8'hFF
`define CRC_XOROUT     8'h00
`define ID_WORDS       3'h6
`define ID_BYTES       5'h12
`define WORD_POS_CRC   2'h2
`define RW_WRITE       1'b0
`define RW_READ        1'b1
`define REV_BITS       8
`define SCALE_P_WIDE   16'sh003C
`define SCALE_P_NARROW 16'sh00F0
`define SCALE_T        16'sh00C8
`define CLK_MHZ        250
`define QTR_NS         625
`define QTR_CYC        ((`QTR_NS * `CLK_MHZ) / 1000)
`define PH_RX          4'hC
`define PH_LAST        4'hD

`endif

// >>> verilog/id_readout_pkg.sv
/*
 * Types and the checksum function shared by both ends.
 * Assumes id_readout_defines.svh is on the include path.
 */
`include "id_readout_defines.svh"
package id_readout_pkg;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_AACK = 3'h2,
		D_WR   = 3'h3,
		D_WACK = 3'h4,
		D_RD   = 3'h5,
		D_RACK = 3'h6
	} dev_state_e;

	typedef enum logic [0:0] {
		H_IDLE = 1'h0,
		H_RUN  = 1'h1
	} host_state_e;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_TX    = 2'h1,
		OP_RX    = 2'h2,
		OP_STOP  = 2'h3
	} link_op_e;

	// MSB first, no reflection
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = `CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ d[i])
				c = {c[6:0], 1'b0} ^ `CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		return c ^ `CRC_XOROUT;
	endfunction : crc8

endpackage : id_readout_pkg

// >>> verilog/id_link_if.sv
/*
 * Two-wire link between host and device, open-drain.
 * Assumes both ends run on the same clock; an enable high pulls the wire low.
 */
`timescale 1ns/1ns
interface id_link_if;
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (
		output host_scl_oe,
		output host_sda_oe,
		input  scl,
		input  sda
	);

	modport dev (
		output dev_sda_oe,
		input  scl,
		input  sda
	);
endinterface : id_link_if

// >>> verilog/id_readout_dev.sv
/*
 * Device end: two-wire target answering the two-command identification read
 * with 18 bytes (six 16-bit words, each followed by a checksum).
 * Assumes link pins synchronous to clk and a host that never stretches timing.
 */
`timescale 1ns/1ns
`include "id_readout_defines.svh"
module id_readout_dev #(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// System
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Link
	id_link_if.dev           link,
	// Identity contents
	input  wire logic [31:0] product_num,
	input  wire logic [63:0] serial_num,
	// Status
	output logic             id_ready
);
	import id_readout_pkg::*;

	if (DEV_ADDR == 7'h00) begin : g_chk
		$error("DEV_ADDR 0 is the general call address");
	end

	dev_state_e  st_ff, nxt_st;
	logic        scl_ff, sda_ff;
	logic [3:0]  bit_ff, nxt_bit;
	logic [7:0]  sh_ff, nxt_sh;
	logic [7:0]  hi_ff, nxt_hi;
	logic        rw_ff, nxt_rw;
	logic        cmd2_ff, nxt_cmd2;
	logic        armed_ff, nxt_armed;
	logic        rdy_ff, nxt_rdy;
	logic [2:0]  w_ff, nxt_w;
	logic [1:0]  pos_ff, nxt_pos;
	logic        ack_ff, nxt_ack;
	logic        oe_ff, nxt_oe;
	logic        start, stop, rise, fall;
	logic [95:0] stream;
	logic [15:0] word;
	logic [7:0]  cur_byte;

	assign start = scl_ff & link.scl & sda_ff & ~link.sda;
	assign stop  = scl_ff & link.scl & ~sda_ff & link.sda;
	assign rise  = link.scl & ~scl_ff;
	assign fall  = ~link.scl & scl_ff;

	// Product number then serial number, MSB first
	assign stream   = {product_num, serial_num};
	assign word     = 16'(stream >> (7'd80 - {w_ff, 4'h0}));
	// Checksum covers only the two data bytes before it
	assign cur_byte = (pos_ff == 2'h0) ? word[15:8] :
			  (pos_ff == 2'h1) ? word[7:0] : crc8(word);

	always_comb begin
		nxt_st    = st_ff;
		nxt_bit   = bit_ff;
		nxt_sh    = sh_ff;
		nxt_hi    = hi_ff;
		nxt_rw    = rw_ff;
		nxt_cmd2  = cmd2_ff;
		nxt_armed = armed_ff;
		nxt_rdy   = rdy_ff;
		nxt_w     = w_ff;
		nxt_pos   = pos_ff;
		nxt_ack   = ack_ff;
		nxt_oe    = oe_ff;
		if (start) begin
			nxt_st  = D_ADDR;
			nxt_bit = 4'h0;
			nxt_oe  = 1'b0;
		end else if (stop) begin
			nxt_st = D_IDLE;
			nxt_oe = 1'b0;
		end else begin
			case (st_ff)
			D_ADDR, D_WR: begin
				if (rise && bit_ff != 4'h8) begin
					nxt_sh  = {sh_ff[6:0], link.sda};
					nxt_bit = bit_ff + 4'h1;
				end else if (fall && bit_ff == 4'h8) begin
					if (st_ff == D_WR) begin
						nxt_oe = 1'b1;
						nxt_st = D_WACK;
					end else if (sh_ff[7:1] == DEV_ADDR &&
						     (sh_ff[0] == `RW_WRITE || rdy_ff)) begin
						// Reads are refused until the id sequence is complete
						nxt_oe = 1'b1;
						nxt_rw = sh_ff[0];
						nxt_st = D_AACK;
					end else begin
						nxt_st = D_IDLE;
					end
				end
			end
			D_AACK: begin
				if (fall) begin
					nxt_bit = 4'h0;
					if (rw_ff == `RW_READ) begin
						nxt_sh = cur_byte;
						nxt_oe = ~cur_byte[7];
						nxt_st = D_RD;
					end else begin
						nxt_oe   = 1'b0;
						nxt_cmd2 = 1'b0;
						nxt_st   = D_WR;
					end
				end
			end
			D_WACK: begin
				if (fall) begin
					nxt_oe  = 1'b0;
					nxt_bit = 4'h0;
					if (!cmd2_ff) begin
						nxt_hi   = sh_ff;
						nxt_cmd2 = 1'b1;
						nxt_st   = D_WR;
					end else begin
						// Extra bytes in this transfer are not acknowledged
						nxt_st = D_IDLE;
						if ({hi_ff, sh_ff} == `CMD_ID_FIRST) begin
							nxt_armed = 1'b1;
							nxt_rdy   = 1'b0;
						end else if ({hi_ff, sh_ff} == `CMD_ID_SECOND && armed_ff) begin
							nxt_armed = 1'b0;
							nxt_rdy   = 1'b1;
							nxt_w     = 3'h0;
							nxt_pos   = 2'h0;
						end else begin
							nxt_armed = 1'b0;
							nxt_rdy   = 1'b0;
						end
					end
				end
			end
			D_RD: begin
				if (fall) begin
					if (bit_ff == 4'h7) begin
						nxt_oe = 1'b0;
						nxt_st = D_RACK;
						if (pos_ff == `WORD_POS_CRC) begin
							nxt_pos = 2'h0;
							nxt_w   = w_ff + 3'h1;
						end else begin
							nxt_pos = pos_ff + 2'h1;
						end
					end else begin
						nxt_bit = bit_ff + 4'h1;
						nxt_sh  = {sh_ff[6:0], 1'b0};
						nxt_oe  = ~sh_ff[6];
					end
				end
			end
			D_RACK: begin
				if (rise)
					nxt_ack = ~link.sda;
				else if (fall) begin
					if (ack_ff && w_ff != `ID_WORDS) begin
						nxt_sh  = cur_byte;
						nxt_oe  = ~cur_byte[7];
						nxt_bit = 4'h0;
						nxt_st  = D_RD;
					end else begin
						// Host nack, or the last byte of the sixth word, ends the stream
						nxt_st  = D_IDLE;
						nxt_rdy = 1'b0;
					end
				end
			end
			default: nxt_oe = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff    <= D_IDLE;
			scl_ff   <= 1'b1;
			sda_ff   <= 1'b1;
			bit_ff   <= 4'h0;
			sh_ff    <= 8'h00;
			hi_ff    <= 8'h00;
			rw_ff    <= 1'b0;
			cmd2_ff  <= 1'b0;
			armed_ff <= 1'b0;
			rdy_ff   <= 1'b0;
			w_ff     <= 3'h0;
			pos_ff   <= 2'h0;
			ack_ff   <= 1'b0;
			oe_ff    <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			scl_ff   <= link.scl;
			sda_ff   <= link.sda;
			bit_ff   <= nxt_bit;
			sh_ff    <= nxt_sh;
			hi_ff    <= nxt_hi;
			rw_ff    <= nxt_rw;
			cmd2_ff  <= nxt_cmd2;
			armed_ff <= nxt_armed;
			rdy_ff   <= nxt_rdy;
			w_ff     <= nxt_w;
			pos_ff   <= nxt_pos;
			ack_ff   <= nxt_ack;
			oe_ff    <= nxt_oe;
		end
	end

	assign link.dev_sda_oe = oe_ff;
	assign id_ready        = rdy_ff;

endmodule : id_readout_dev

// >>> verilog/id_readout_host.sv
/*
 * Host end: two-wire controller that issues the identification sequence,
 * reads up to 18 bytes, checks checksums and part type, and scales samples.
 * Assumes a device end on the same clock that does not stretch the clock.
 */
`timescale 1ns/1ns
`include "id_readout_defines.svh"
module id_readout_host #(
	parameter logic [6:0]  DEV_ADDR = 7'h40,
	parameter logic [23:0] EXP_PART = 24'h00A5A5, // Arbitrary part code
	parameter bit          NARROW   = 1'b0,
	parameter int          QTR_CYC  = `QTR_CYC
) (
	// System
	input  wire logic               clk,
	input  wire logic               rst_b,
	// Link
	id_link_if.host                 link,
	// Identification request
	input  wire logic               go,
	input  wire logic [4:0]         rd_len,
	output logic                    busy,
	output logic                    done,
	output logic                    nack_err,
	output logic                    crc_err,
	output logic                    part_ok,
	output logic [31:0]             product_num,
	output logic [63:0]             serial_num,
	// Sample conversion
	input  wire logic               conv_go,
	input  wire logic signed [15:0] pres_raw,
	input  wire logic signed [15:0] temp_raw,
	output logic signed [15:0]      pres_pa,
	output logic signed [15:0]      temp_c,
	output logic                    conv_done
);
	import id_readout_pkg::*;

	if (QTR_CYC < 1 || QTR_CYC > 65535) begin : g_chk
		$error("QTR_CYC out of range");
	end

	localparam logic [15:0]        QTR_LAST = 16'(QTR_CYC - 1);
	localparam logic signed [15:0] P_SCALE  = NARROW ? `SCALE_P_NARROW : `SCALE_P_WIDE;

	host_state_e st_ff, nxt_st;
	logic [15:0] tick_ff, nxt_tick;
	logic [1:0]  q_ff, nxt_q;
	logic [3:0]  ph_ff, nxt_ph;
	logic [3:0]  bit_ff, nxt_bit;
	logic [7:0]  tx_ff, nxt_tx;
	logic [7:0]  rx_ff, nxt_rx;
	logic [4:0]  rxn_ff, nxt_rxn;
	logic [4:0]  len_ff, nxt_len;
	logic        sclo_ff, nxt_sclo;
	logic        sdao_ff, nxt_sdao;
	logic [95:0] data_ff, nxt_data;
	logic [7:0]  hi_ff, nxt_hi;
	logic [7:0]  lo_ff, nxt_lo;
	logic [1:0]  pos_ff, nxt_pos;
	logic        crc_err_ff, nxt_crc_err;
	logic        nack_ff, nxt_nack;
	logic        done_ff, nxt_done;
	logic        part_ok_ff, nxt_part_ok;
	logic        step, adv, last_rx;
	logic signed [15:0] pres_ff, nxt_pres;
	logic signed [15:0] temp_ff, nxt_temp;
	logic        conv_ff, nxt_conv;

	// Fixed transfer plan: two write transfers, then one read transfer
	function automatic link_op_e ph_op(input logic [3:0] ph);
		case (ph)
		4'h0, 4'h5, 4'hA: ph_op = OP_START;
		4'h4, 4'h9, `PH_LAST: ph_op = OP_STOP;
		`PH_RX: ph_op = OP_RX;
		default: ph_op = OP_TX;
		endcase
	endfunction : ph_op

	function automatic logic [7:0] ph_byte(input logic [3:0] ph);
		case (ph)
		4'h1, 4'h6: ph_byte = {DEV_ADDR, `RW_WRITE};
		4'h2: ph_byte = 8'(`CMD_ID_FIRST >> 8);
		4'h3: ph_byte = 8'(`CMD_ID_FIRST);
		4'h7: ph_byte = 8'(`CMD_ID_SECOND >> 8);
		4'h8: ph_byte = 8'(`CMD_ID_SECOND);
		4'hB: ph_byte = {DEV_ADDR, `RW_READ};
		default: ph_byte = 8'h00;
		endcase
	endfunction : ph_byte

	assign last_rx = (rxn_ff + 5'h01 == len_ff);

	always_comb begin
		nxt_st      = st_ff;
		nxt_tick    = tick_ff;
		nxt_q       = q_ff;
		nxt_ph      = ph_ff;
		nxt_bit     = bit_ff;
		nxt_tx      = tx_ff;
		nxt_rx      = rx_ff;
		nxt_rxn     = rxn_ff;
		nxt_len     = len_ff;
		nxt_sclo    = sclo_ff;
		nxt_sdao    = sdao_ff;
		nxt_data    = data_ff;
		nxt_hi      = hi_ff;
		nxt_lo      = lo_ff;
		nxt_pos     = pos_ff;
		nxt_crc_err = crc_err_ff;
		nxt_nack    = nack_ff;
		nxt_done    = 1'b0;
		nxt_part_ok = part_ok_ff;
		step        = (tick_ff == QTR_LAST);
		adv         = 1'b0;
		case (st_ff)
		H_IDLE: begin
			nxt_sclo = 1'b0;
			nxt_sdao = 1'b0;
			if (go) begin
				nxt_st      = H_RUN;
				nxt_tick    = 16'h0000;
				nxt_q       = 2'h0;
				nxt_ph      = 4'h0;
				nxt_bit     = 4'h0;
				nxt_rxn     = 5'h00;
				nxt_pos     = 2'h0;
				nxt_crc_err = 1'b0;
				nxt_nack    = 1'b0;
				nxt_part_ok = 1'b0;
				// Shorter reads end early by nack
				nxt_len = (rd_len == 5'h00 || rd_len > `ID_BYTES) ? `ID_BYTES : rd_len;
			end
		end
		default: begin
			nxt_tick = step ? 16'h0000 : tick_ff + 16'h0001;
			if (step) begin
				nxt_q = q_ff + 2'h1;
				case (ph_op(ph_ff))
				OP_START: begin
					case (q_ff)
					2'h0: begin
						nxt_sclo = 1'b0;
						nxt_sdao = 1'b0;
					end
					2'h1: nxt_sdao = 1'b1;
					2'h2: nxt_sclo = 1'b1;
					default: adv = 1'b1;
					endcase
				end
				OP_STOP: begin
					case (q_ff)
					2'h0: begin
						nxt_sclo = 1'b1;
						nxt_sdao = 1'b1;
					end
					2'h1: nxt_sclo = 1'b0;
					2'h2: nxt_sdao = 1'b0;
					default: begin
						if (ph_ff == `PH_LAST) begin
							nxt_st      = H_IDLE;
							nxt_done    = 1'b1;
							// Revision byte may change between lots
							nxt_part_ok = ~crc_err_ff & ~nack_ff &
								(rxn_ff == `ID_BYTES) &
								(data_ff[95:72] == EXP_PART);
						end else begin
							adv = 1'b1;
						end
					end
					endcase
				end
				default: begin
					case (q_ff)
					2'h0: begin
						nxt_sclo = 1'b1;
						if (bit_ff != 4'h8)
							nxt_sdao = (ph_op(ph_ff) == OP_TX) ? ~tx_ff[7] : 1'b0;
						else
							nxt_sdao = (ph_op(ph_ff) == OP_RX) & ~last_rx;
					end
					2'h1: nxt_sclo = 1'b0;
					2'h2: begin
						if (bit_ff != 4'h8)
							nxt_rx = {rx_ff[6:0], link.sda};
						else if (ph_op(ph_ff) == OP_TX && link.sda)
							nxt_nack = 1'b1;
					end
					default: begin
						nxt_sclo = 1'b1;
						nxt_tx   = {tx_ff[6:0], 1'b0};
						nxt_bit  = bit_ff + 4'h1;
						if (bit_ff == 4'h8) begin
							nxt_bit = 4'h0;
							if (ph_op(ph_ff) == OP_TX) begin
								if (nack_ff)
									nxt_ph = `PH_LAST;
								else
									adv = 1'b1;
							end else begin
								nxt_rxn = rxn_ff + 5'h01;
								nxt_pos = pos_ff + 2'h1;
								if (pos_ff == 2'h0)
									nxt_hi = rx_ff;
								else if (pos_ff == 2'h1)
									nxt_lo = rx_ff;
								else begin
									nxt_pos  = 2'h0;
									nxt_data = {data_ff[79:0], hi_ff, lo_ff};
									if (crc8({hi_ff, lo_ff}) != rx_ff)
										nxt_crc_err = 1'b1;
								end
								if (last_rx)
									nxt_ph = `PH_LAST;
							end
						end
					end
					endcase
				end
				endcase
				if (adv) begin
					nxt_ph  = ph_ff + 4'h1;
					nxt_tx  = ph_byte(ph_ff + 4'h1);
					nxt_bit = 4'h0;
				end
			end
		end
		endcase
	end

	// Quotient truncates toward zero; finer units need a wider result
	always_comb begin
		nxt_conv = conv_go;
		nxt_pres = pres_ff;
		nxt_temp = temp_ff;
		if (conv_go) begin
			nxt_pres = pres_raw / P_SCALE;
			nxt_temp = temp_raw / `SCALE_T;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff      <= H_IDLE;
			tick_ff    <= 16'h0000;
			q_ff       <= 2'h0;
			ph_ff      <= 4'h0;
			bit_ff     <= 4'h0;
			tx_ff      <= 8'h00;
			rx_ff      <= 8'h00;
			rxn_ff     <= 5'h00;
			len_ff     <= `ID_BYTES;
			sclo_ff    <= 1'b0;
			sdao_ff    <= 1'b0;
			data_ff    <= 96'h0;
			hi_ff      <= 8'h00;
			lo_ff      <= 8'h00;
			pos_ff     <= 2'h0;
			crc_err_ff <= 1'b0;
			nack_ff    <= 1'b0;
			done_ff    <= 1'b0;
			part_ok_ff <= 1'b0;
			pres_ff    <= 16'sh0000;
			temp_ff    <= 16'sh0000;
			conv_ff    <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			tick_ff    <= nxt_tick;
			q_ff       <= nxt_q;
			ph_ff      <= nxt_ph;
			bit_ff     <= nxt_bit;
			tx_ff      <= nxt_tx;
			rx_ff      <= nxt_rx;
			rxn_ff     <= nxt_rxn;
			len_ff     <= nxt_len;
			sclo_ff    <= nxt_sclo;
			sdao_ff    <= nxt_sdao;
			data_ff    <= nxt_data;
			hi_ff      <= nxt_hi;
			lo_ff      <= nxt_lo;
			pos_ff     <= nxt_pos;
			crc_err_ff <= nxt_crc_err;
			nack_ff    <= nxt_nack;
			done_ff    <= nxt_done;
			part_ok_ff <= nxt_part_ok;
			pres_ff    <= nxt_pres;
			temp_ff    <= nxt_temp;
			conv_ff    <= nxt_conv;
		end
	end

	assign link.host_scl_oe = sclo_ff;
	assign link.host_sda_oe = sdao_ff;
	assign busy             = (st_ff == H_RUN);
	assign done             = done_ff;
	assign nack_err         = nack_ff;
	assign crc_err          = crc_err_ff;
	assign part_ok          = part_ok_ff;
	assign product_num      = data_ff[95:64];
	assign serial_num       = data_ff[63:0];
	assign pres_pa          = pres_ff;
	assign temp_c           = temp_ff;
	assign conv_done        = conv_ff;

endmodule : id_readout_host

// >>> tb/sensor_id_crc_readout_properties.sv
/*
 * Concurrent checks on the two-wire link between host and device ends,
 * plus the host's busy/done handshake and the device's ready flag.
 * Assumes one clock for both ends and plain inputs wired from the bench.
 */
`timescale 1ns/1ns
module sensor_id_crc_readout_properties (
	// System
	input wire logic clk,
	input wire logic rst_b,
	// Link wires
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	// Host user side
	input wire logic go,
	input wire logic busy,
	input wire logic done,
	// Device status
	input wire logic id_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_reset_idle;
		$rose(rst_b) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe && !busy && !id_ready;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("lines not idle after reset");

	property p_idle_lines;
		!busy && !done |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe;
	endproperty
	a_idle_lines: assert property (p_idle_lines) else $error("link driven while host idle");

	// Device data may only move while the clock line is low
	property p_dev_scl_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_scl_low: assert property (p_dev_scl_low) else $error("device sda moved, scl high");

	property p_start_host;
		$fell(sda) && scl |-> host_sda_oe && !dev_sda_oe;
	endproperty
	a_start_host: assert property (p_start_host) else $error("start not made by host");

	property p_go_start;
		go && !busy |=> busy ##[1:16] (scl && !sda);
	endproperty
	a_go_start: assert property (p_go_start) else $error("no start after go");

	property p_done_fell;
		done |-> $fell(busy);
	endproperty
	a_done_fell: assert property (p_done_fell) else $error("done without busy end");

	property p_fell_done;
		$fell(busy) |-> done;
	endproperty
	a_fell_done: assert property (p_fell_done) else $error("busy ended without done");

	property p_ready_busy;
		$rose(id_ready) |-> busy;
	endproperty
	a_ready_busy: assert property (p_ready_busy) else $error("ready rose with no sequence");
endmodule : sensor_id_crc_readout_properties

// >>> tb/sensor_id_crc_readout_bench.sv
/*
 * Bench: host and device ends joined on one link, a second host facing
 * a silent far end; reads, early ends, part checks and conversions.
 * Assumes the design files under verilog/ and a small quarter count.
 */
`timescale 1ns/1ns
module sensor_id_crc_readout_bench;
	localparam logic [23:0] PART = 24'h00A5A5; // Arbitrary part code
	logic                clk = 1'b0;
	logic                rst_b = 1'b0;
	logic                go = 1'b0;
	logic                conv_go = 1'b0;
	logic [4:0]          rd_len = 5'h00;
	logic signed [15:0]  pres_raw = 16'sh0000;
	logic signed [15:0]  temp_raw = 16'sh0000;
	logic [31:0]         prod = 32'h00000000;
	logic [63:0]         ser = 64'h0;
	logic                busy, done, nack_err, crc_err, part_ok, id_ready, conv_done;
	logic [31:0]         pn;
	logic [63:0]         sn;
	logic signed [15:0]  pres_pa, temp_c, pres2, temp2;
	logic                busy2, nack2;
	logic                scl_q = 1'b1;
	logic                sda_q = 1'b1;
	logic [8:0]          sh = 9'h000;
	int                  nb = 0;
	int                  err_total = 0;
	int                  cmp_count = 0;
	logic [7:0]          wq[$];
	logic signed [15:0]  tp[4] = '{16'sh7FFF, -16'sd61, 16'sd59, 16'sh8000};
	logic signed [15:0]  tt[4] = '{-16'sd201, 16'sd199, 16'sh7FFF, 16'sh8000};

	always #2 clk = ~clk;

	id_link_if link();
	id_link_if link2();
	// Far end that never answers
	assign link2.dev_sda_oe = 1'b0;

	id_readout_dev u_id_readout_dev (.clk(clk), .rst_b(rst_b), .link(link),
		.product_num(prod), .serial_num(ser), .id_ready(id_ready));
	id_readout_host #(.EXP_PART(PART), .QTR_CYC(2)) u_id_readout_host (.clk(clk),
		.rst_b(rst_b), .link(link), .go(go), .rd_len(rd_len), .busy(busy), .done(done),
		.nack_err(nack_err), .crc_err(crc_err), .part_ok(part_ok), .product_num(pn),
		.serial_num(sn), .conv_go(conv_go), .pres_raw(pres_raw), .temp_raw(temp_raw),
		.pres_pa(pres_pa), .temp_c(temp_c), .conv_done(conv_done));
	id_readout_host #(.EXP_PART(PART), .NARROW(1'b1), .QTR_CYC(2)) u_id_readout_host_2 (
		.clk(clk), .rst_b(rst_b), .link(link2), .go(go), .rd_len(rd_len), .busy(busy2),
		.done(), .nack_err(nack2), .crc_err(), .part_ok(), .product_num(), .serial_num(),
		.conv_go(conv_go), .pres_raw(pres_raw), .temp_raw(temp_raw), .pres_pa(pres2),
		.temp_c(temp2), .conv_done());
	sensor_id_crc_readout_properties u_sensor_id_crc_readout_properties (.clk(clk),
		.rst_b(rst_b), .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda), .go(go),
		.busy(busy), .done(done), .id_ready(id_ready));

	// Wire monitor: nine bits a byte, the ninth is the acknowledge
	always @(posedge clk) begin
		if (link.scl && scl_q && sda_q && !link.sda)
			nb = 0;
		else if (link.scl && !scl_q) begin
			sh = {sh[7:0], link.sda};
			nb++;
			if (nb == 9) begin
				wq.push_back(sh[8:1]);
				nb = 0;
			end
		end
		scl_q = link.scl;
		sda_q = link.sda;
	end

	function automatic logic [7:0] crc_ref(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--)
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		return c;
	endfunction : crc_ref

	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic do_read(input logic [4:0] len, input logic [31:0] p, input logic [63:0] s);
		int n;
		wq.delete();
		@(posedge clk);
		go <= 1'b1;
		rd_len <= len;
		prod <= p;
		ser <= s;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			err_total++;
			conclude();
		end
	endtask : do_read

	// Expected bytes on the wire: two command transfers, then the read
	task automatic wire_chk(input logic [4:0] len);
		int k;
		logic [95:0] w;
		logic [15:0] wd;
		logic [7:0] ex[$];
		w = {prod, ser};
		ex = '{8'h80, 8'h36, 8'h7C, 8'h80, 8'hE1, 8'h02, 8'h81};
		for (k = 0; k < ((len == 0 || len > 18) ? 18 : len); k++) begin
			wd = w[95 - 16 * (k / 3) -: 16];
			ex.push_back(k % 3 == 0 ? wd[15:8] : (k % 3 == 1 ? wd[7:0] : crc_ref(wd)));
		end
		chk(wq.size(), ex.size());
		for (k = 0; k < ex.size() && k < wq.size(); k++)
			chk(wq[k], ex[k]);
	endtask : wire_chk

	task automatic conv(input logic signed [15:0] p, input logic signed [15:0] t);
		int n;
		@(posedge clk);
		pres_raw <= p;
		temp_raw <= t;
		conv_go <= 1'b1;
		@(posedge clk);
		conv_go <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (conv_done !== 1'b1 && n < 8);
		chk(n < 8, 1'b1);
		if (n >= 8)
			conclude();
		chk(64'(pres_pa), 64'(p / 16'sd60));
		chk(64'(pres2), 64'(p / 16'sd240));
		chk(64'(temp_c), 64'(t / 16'sd200));
		chk(64'(temp2), 64'(t / 16'sd200));
	endtask : conv

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		chk(crc_ref(16'hBEEF), 8'h92);
		do_read(5'h00, {PART, 8'h3C}, 64'h0123456789ABCDEF);
		chk(pn, prod);
		chk(sn, ser);
		chk({crc_err, nack_err, part_ok, id_ready}, 4'h2);
		chk({nack2, busy2}, 2'h2);
		wire_chk(5'h00);
		$display("test 1 end, mismatches %0d", err_total);
		// Early end by the host after four bytes
		do_read(5'h04, {PART, 8'h3C}, 64'h0123456789ABCDEF);
		chk({crc_err, nack_err, part_ok, id_ready, link.sda}, 5'h01);
		wire_chk(5'h04);
		$display("test 2 end, mismatches %0d", err_total);
		// Revision byte changed: part still accepted
		do_read(5'h12, {PART, 8'hC7}, 64'hFEDCBA9876543210);
		chk(sn, ser);
		chk({crc_err, part_ok}, 2'h1);
		wire_chk(5'h12);
		$display("test 3 end, mismatches %0d", err_total);
		// Part code changed: refused
		do_read(5'h13, {PART ^ 24'h000100, 8'h3C}, 64'h8000000000000001);
		chk(pn, prod);
		chk({crc_err, nack_err, part_ok}, 3'h0);
		wire_chk(5'h13);
		$display("test 4 end, mismatches %0d", err_total);
		for (int i = 0; i < 4; i++)
			conv(tp[i], tt[i]);
		$display("test 5 end, mismatches %0d", err_total);
		conclude();
	end
endmodule : sensor_id_crc_readout_bench
